// *** src/rtc_clock_select.sv ***
// Purpose: Clock source select, pseudo-stop enables, modulation control and periodic timer rate
// Assumes: Timer ticks, stop and oscillator status arrive as inputs; ticks are clk_sys pulses
// Notes: Reads wait one cycle for registered data; writes complete in the request cycle
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Functional notes
// - Clock-select bit 2 lets watchdog run in pseudo stop only with oscillator source
// - Otherwise watchdog freezes in any stop mode and keeps its count
// - Clock-select bit 1 picks periodic timer clock: 0 internal RC, 1 oscillator
// - Any change of periodic timer clock select restarts its period
// - Periodic timer clock select sets only with oscillator up; forced 0 otherwise
// - Watchdog select high,low: 00 internal RC, 01 oscillator, 1x auxiliary RC
// - With high select 1, low select neither chooses nor restarts watchdog
// - With high select 0, any low select change restarts watchdog period
// - Low watchdog select sets only with oscillator up; cleared when it drops
// - Modulation register at 0x0A resets zero, bits 5 and 4 only
// - Modulation writes need write-protect 0 and loop clock select 1
// - Accepted modulation write clears lock and oscillator-up status
// - Modulation select: off, 1, 2 or 4 percent
// - Modulation frequency equals reference frequency divided by 16
// - Periodic timer runs in stop only in pseudo stop with oscillator clock
// - Rate register at 0x0B always writable; every write restarts the period
// - Rate bit 7 picks binary or decimal divider table
// - Rate bits 6:4 prescale, bits 3:0 modulus multiplier
// - Binary: code 0 off, 1..7 give 2^10..2^16, modulus n multiplies by n+1
module rtc_clock_select
  import rtc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_readdatavalid,
  output logic avs_waitrequest,
  input wire logic osc_up_status_pin,
  input wire logic write_protect,
  input wire logic stop_mode,
  input wire logic ref_tick,
  input wire logic pt_tick_rc,
  input wire logic pt_tick_osc,
  output logic [1:0] wdog_clk_source,
  output logic wdog_run,
  output logic wdog_restart,
  output logic periodic_timer_clk_select,
  output logic periodic_timer_irq,
  output logic [1:0] modulation_amplitude,
  output logic modulation_tick,
  output logic lock_clear,
  output logic osc_up_clear
);
  rtc_state_type r;
  rtc_state_type next_r;

  // ==========================================================================
  // Helpers
  // Binary prescale exponent is code plus 9 (code 1 gives 2^10)
  function automatic logic [RTC_CNT_W-1:0] rtc_period(input logic [7:0] rate);
    logic [RTC_CNT_W-1:0] base;
    base = '0;
    if (rate[RTC_RATE_DEC]) begin
      unique case (rate[6:4])
        3'h0: base = 21'd1000;
        3'h1: base = 21'd2000;
        3'h2: base = 21'd5000;
        3'h3: base = 21'd10000;
        3'h4: base = 21'd20000;
        3'h5: base = 21'd50000;
        3'h6: base = 21'd100000;
        default: base = 21'd200000;
      endcase
    end else if (rate[6:4] != 3'h0) begin
      base = RTC_CNT_W'(21'd1 << (5'd9 + 5'(rate[6:4])));
    end
    return base;
  endfunction

  function automatic logic rtc_off(input logic [7:0] rate);
    return !rate[RTC_RATE_DEC] && rate[6:4] == 3'h0;
  endfunction

  // Register decode, shared by the three write strobes
  function automatic logic rtc_hit(input logic strobe, input logic [3:0] addr, input logic [3:0] idx);
    return strobe && addr == idx;
  endfunction

  logic osc_up;
  logic wr_lane0;
  logic wr_cs;
  logic wr_fm;
  logic wr_rate;
  logic fm_ok;
  logic pt_sel_eff;
  logic wd_low_eff;
  logic pt_run;
  logic pt_tick;
  logic [7:0] cs_wdata;
  logic rd_take;

  // Filtered oscillator-up level; it only moves once the last two stages agree
  assign osc_up = r.osc_up;
  // Lane 0 carries every register byte; writes on other lanes alone are dropped
  assign wr_lane0 = avs_write & avs_byteenable[0];
  assign wr_cs = rtc_hit(wr_lane0, avs_address, RTC_IDX_CLK_SEL);
  assign wr_fm = rtc_hit(wr_lane0, avs_address, RTC_IDX_FM);
  assign wr_rate = rtc_hit(wr_lane0, avs_address, RTC_IDX_RATE);
  // A read waits one cycle so that the answer comes from flip-flops
  assign rd_take = avs_read && !r.rd_valid;
  assign fm_ok = !write_protect && r.clk_sel[RTC_CS_LOOP_SEL];
  assign cs_wdata = avs_writedata[7:0];

  // ==========================================================================
  // Next state
  always_comb begin
    next_r = r;
    next_r.osc_sync = {r.osc_sync[1:0], osc_up_status_pin};
    // A lone odd sample from a slow pin edge cannot flip the status
    if (r.osc_sync[1] == r.osc_sync[2]) begin
      next_r.osc_up = r.osc_sync[2];
    end
    next_r.wd_restart = 1'b0;
    next_r.pt_restart = 1'b0;
    next_r.lock_clr = 1'b0;
    next_r.osc_clr = 1'b0;
    next_r.fm_tick = 1'b0;
    next_r.pt_flag = 1'b0;
    next_r.rd_valid = rd_take;
    next_r.rd_data = 8'h00;
    // Clock select writes; oscillator-dependent bits only set while it is up
    if (wr_cs) begin
      next_r.clk_sel = cs_wdata;
      next_r.clk_sel[RTC_CS_PT_SEL] = cs_wdata[RTC_CS_PT_SEL] & osc_up;
      next_r.clk_sel[RTC_CS_WD_LOW] = cs_wdata[RTC_CS_WD_LOW] & osc_up;
      next_r.clk_sel[RTC_CS_RSVD] = 1'b0; // Unused bit reads 0
    end
    // Oscillator loss auto-clears both oscillator selections
    if (!osc_up) begin
      next_r.clk_sel[RTC_CS_PT_SEL] = 1'b0;
      next_r.clk_sel[RTC_CS_WD_LOW] = 1'b0;
    end
    // Restarts come from any actual change of the effective select bits.
    // Comparing against the next value catches a write and an auto-clear alike,
    // so a loss of the oscillator restarts the period just as software would.
    if (next_r.clk_sel[RTC_CS_PT_SEL] != r.clk_sel[RTC_CS_PT_SEL]) begin
      next_r.pt_restart = 1'b1;
    end
    if (next_r.clk_sel[RTC_CS_WD_HIGH] != r.clk_sel[RTC_CS_WD_HIGH]) begin
      next_r.wd_restart = 1'b1;
    end
    if (!r.clk_sel[RTC_CS_WD_HIGH] && !next_r.clk_sel[RTC_CS_WD_HIGH] &&
        next_r.clk_sel[RTC_CS_WD_LOW] != r.clk_sel[RTC_CS_WD_LOW]) begin
      next_r.wd_restart = 1'b1;
    end
    // Protected modulation register
    if (wr_fm && fm_ok) begin
      next_r.fm = cs_wdata & RTC_FM_MASK;
      next_r.lock_clr = 1'b1;
      next_r.osc_clr = 1'b1;
    end
    // Modulation tick at reference over 16
    if (r.fm[5:4] != 2'b00 && ref_tick) begin
      next_r.fm_div = r.fm_div + 4'h1;
      next_r.fm_tick = r.fm_div == RTC_FM_DIV_LAST;
    end else if (r.fm[5:4] == 2'b00) begin
      next_r.fm_div = 4'h0;
    end
    // Periodic timer counter; ticks are enables, so no clock is ever gated here.
    // A restart wins over a counting tick in the same cycle.
    if (wr_rate || next_r.pt_restart) begin
      if (wr_rate) begin
        next_r.rate = cs_wdata;
      end
      next_r.pre_cnt = '0;
      next_r.mod_cnt = 4'h0;
    end else if (pt_run && pt_tick && !rtc_off(r.rate)) begin
      if (r.pre_cnt == rtc_period(r.rate) - 21'd1) begin
        next_r.pre_cnt = '0;
        if (r.mod_cnt == r.rate[3:0]) begin
          next_r.mod_cnt = 4'h0;
          next_r.pt_flag = 1'b1;
        end else begin
          next_r.mod_cnt = r.mod_cnt + 4'h1;
        end
      end else begin
        next_r.pre_cnt = r.pre_cnt + 21'd1;
      end
    end
    // Read data
    if (rd_take) begin
      unique case (avs_address)
        RTC_IDX_CLK_SEL: next_r.rd_data = r.clk_sel;
        RTC_IDX_FM: next_r.rd_data = r.fm;
        RTC_IDX_RATE: next_r.rd_data = r.rate;
        RTC_IDX_STATUS: next_r.rd_data = {7'h00, osc_up};
        default: next_r.rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      r <= '0;
      r.clk_sel <= RTC_CS_RESET;
      r.fm <= RTC_FM_RESET;
      r.rate <= RTC_RATE_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // Run enables and outputs
  assign pt_sel_eff = r.clk_sel[RTC_CS_PT_SEL];
  assign wd_low_eff = r.clk_sel[RTC_CS_WD_LOW];
  assign pt_tick = pt_sel_eff ? pt_tick_osc : pt_tick_rc;
  // Stop mode halts unless pseudo stop, enable and oscillator clock all hold
  // Limitation: stop halts the count but keeps it; nothing here clears it on exit
  assign pt_run = !stop_mode ||
    (r.clk_sel[RTC_CS_PSTOP_SEL] && r.clk_sel[RTC_CS_PT_PSTOP_EN] && pt_sel_eff);
  assign wdog_run = !stop_mode ||
    (r.clk_sel[RTC_CS_PSTOP_SEL] && r.clk_sel[RTC_CS_PSTOP_EN] && !r.clk_sel[RTC_CS_WD_HIGH] && wd_low_eff);
  // High select dominates the low one
  assign wdog_clk_source = r.clk_sel[RTC_CS_WD_HIGH] ? 2'b10 : {1'b0, wd_low_eff};
  assign wdog_restart = r.wd_restart;
  assign periodic_timer_clk_select = pt_sel_eff;
  assign periodic_timer_irq = r.pt_flag;
  assign modulation_amplitude = r.fm[5:4];
  assign modulation_tick = r.fm_tick;
  assign lock_clear = r.lock_clr;
  assign osc_up_clear = r.osc_clr;
  assign avs_readdata = {24'h000000, r.rd_data};
  assign avs_readdatavalid = r.rd_valid;
  // Writes never wait; a read waits exactly one cycle for its data flop
  assign avs_waitrequest = rd_take;

  // ==========================================================================
  // Checks
  // Properties watch registered state one edge after the request that moves it.
  // Bus-side antecedents come from the master; consequents are what this block
  // drives, so a broken decode or a lost restart shows up here first.
  a_fm_write_guard: assert property (@(posedge clk_sys) disable iff (reset)
    (wr_fm && !fm_ok) |=> $stable(r.fm)) else $error("fm changed on blocked write");
  a_fm_write_clears: assert property (@(posedge clk_sys) disable iff (reset)
    (wr_fm && fm_ok) |=> (lock_clear && osc_up_clear)) else $error("missing status clear");
  a_fm_reserved_zero: assert property (@(posedge clk_sys) disable iff (reset)
    (r.fm & ~RTC_FM_MASK) == 8'h00) else $error("fm reserved bit set");
  a_pt_sel_osc: assert property (@(posedge clk_sys) disable iff (reset)
    !osc_up |=> !periodic_timer_clk_select) else $error("pt select kept without osc");
  a_wd_low_osc: assert property (@(posedge clk_sys) disable iff (reset)
    !osc_up |=> !r.clk_sel[RTC_CS_WD_LOW]) else $error("wd low kept without osc");
  a_pt_change_restart: assert property (@(posedge clk_sys) disable iff (reset)
    $changed(periodic_timer_clk_select) |-> (r.pt_restart && r.pre_cnt == '0)) else $error("no pt restart");
  a_wd_high_masks: assert property (@(posedge clk_sys) disable iff (reset)
    r.clk_sel[RTC_CS_WD_HIGH] |-> wdog_clk_source == 2'b10) else $error("high select not dominant");
  a_wd_low_restart: assert property (@(posedge clk_sys) disable iff (reset)
    (!r.clk_sel[RTC_CS_WD_HIGH] && $past(!r.clk_sel[RTC_CS_WD_HIGH]) && $changed(r.clk_sel[RTC_CS_WD_LOW]))
      |-> wdog_restart) else $error("no wd restart");
  a_rate_write_restart: assert property (@(posedge clk_sys) disable iff (reset)
    wr_rate |=> (r.pre_cnt == '0 && r.mod_cnt == 4'h0)) else $error("rate write no restart");
  a_pt_stop_hold: assert property (@(posedge clk_sys) disable iff (reset)
    (stop_mode && !pt_sel_eff && !wr_rate && !r.pt_restart && osc_up && !wr_cs) |=> $stable(r.pre_cnt))
    else $error("pt ran in stop");
  a_off_no_irq: assert property (@(posedge clk_sys) disable iff (reset)
    (rtc_off(r.rate) && !wr_rate) |=> !periodic_timer_irq) else $error("irq while off");
  // Oscillator status ignores a sample on which the last two stages disagree
  a_osc_filter: assert property (@(posedge clk_sys) disable iff (reset)
    (r.osc_sync[1] != r.osc_sync[2]) |=> $stable(osc_up)) else $error("osc status moved unfiltered");
  // The first read cycle always waits
  a_read_wait: assert property (@(posedge clk_sys) disable iff (reset)
    (avs_read && !r.rd_valid) |-> avs_waitrequest) else $error("read did not wait");
  // Data stands at the edge that sees waitrequest low
  a_read_answer: assert property (@(posedge clk_sys) disable iff (reset)
    (avs_read && !avs_waitrequest) |-> avs_readdatavalid) else $error("read answered without data");
  // Upper lanes are never driven
  a_read_upper: assert property (@(posedge clk_sys) disable iff (reset)
    avs_readdata[31:8] == 24'h000000) else $error("upper read lanes set");
  // Modulation off means no modulation tick
  a_fm_off_quiet: assert property (@(posedge clk_sys) disable iff (reset)
    (r.fm[RTC_FM_HI:RTC_FM_LO] == 2'b00) |=> !modulation_tick) else $error("tick with modulation off");
  // A tick ends a full run of sixteen reference ticks
  a_fm_tick_wrap: assert property (@(posedge clk_sys) disable iff (reset)
    modulation_tick |-> (r.fm_div == 4'h0 && $past(ref_tick))) else $error("tick not on divider wrap");
  // Amplitude only moves on an accepted write
  a_amp_hold: assert property (@(posedge clk_sys) disable iff (reset)
    !(wr_fm && fm_ok) |=> $stable(modulation_amplitude)) else $error("amplitude moved");
  // Low select toggles under the high select restart nothing
  a_wd_high_no_restart: assert property (@(posedge clk_sys) disable iff (reset)
    (r.clk_sel[RTC_CS_WD_HIGH] && $past(r.clk_sel[RTC_CS_WD_HIGH]) && $changed(r.clk_sel[RTC_CS_WD_LOW]))
      |-> !wdog_restart) else $error("masked low select restarted");
  // Without the pseudo-stop enable the watchdog freezes in stop
  a_wd_stop_freeze: assert property (@(posedge clk_sys) disable iff (reset)
    (stop_mode && !r.clk_sel[RTC_CS_PSTOP_EN]) |-> !wdog_run) else $error("watchdog ran in stop");
  // Running in stop implies the oscillator source
  a_wd_pstop_osc: assert property (@(posedge clk_sys) disable iff (reset)
    (stop_mode && wdog_run) |-> wdog_clk_source == 2'b01) else $error("stop run without osc");
  // With high select clear the low select picks RC or oscillator
  a_wd_source_low: assert property (@(posedge clk_sys) disable iff (reset)
    !r.clk_sel[RTC_CS_WD_HIGH] |-> wdog_clk_source == {1'b0, r.clk_sel[RTC_CS_WD_LOW]})
    else $error("wd source wrong");
  // Written select bits land while the oscillator is up
  a_pt_sel_write: assert property (@(posedge clk_sys) disable iff (reset)
    (wr_cs && osc_up) |=> periodic_timer_clk_select == $past(cs_wdata[RTC_CS_PT_SEL]))
    else $error("pt select write lost");
  a_wd_low_write: assert property (@(posedge clk_sys) disable iff (reset)
    (wr_cs && osc_up) |=> r.clk_sel[RTC_CS_WD_LOW] == $past(cs_wdata[RTC_CS_WD_LOW]))
    else $error("wd low write lost");
  // Unused select bit stays clear
  a_cs_reserved: assert property (@(posedge clk_sys) disable iff (reset)
    r.clk_sel[RTC_CS_RSVD] == 1'b0) else $error("unused select bit set");
  // A restart leaves the whole count at zero
  a_pt_restart_clear: assert property (@(posedge clk_sys) disable iff (reset)
    r.pt_restart |-> (r.pre_cnt == '0 && r.mod_cnt == 4'h0)) else $error("restart kept count");
  // The flag is one cycle wide and both counters wrap with it
  a_irq_single: assert property (@(posedge clk_sys) disable iff (reset)
    periodic_timer_irq |=> !periodic_timer_irq) else $error("flag too wide");
  a_irq_mod_wrap: assert property (@(posedge clk_sys) disable iff (reset)
    periodic_timer_irq |-> (r.mod_cnt == 4'h0 && r.pre_cnt == '0)) else $error("flag without wrap");
  // A rate write stores its byte
  a_rate_write_value: assert property (@(posedge clk_sys) disable iff (reset)
    wr_rate |=> r.rate == $past(cs_wdata)) else $error("rate write lost");
  // Off setting holds the count still
  a_off_hold: assert property (@(posedge clk_sys) disable iff (reset)
    (rtc_off(r.rate) && !wr_rate && !wr_cs && osc_up) |=> $stable(r.pre_cnt)) else $error("count ran while off");
  c_irq: cover property (@(posedge clk_sys) periodic_timer_irq);
  c_read_wait: cover property (@(posedge clk_sys) avs_read && avs_waitrequest);
  c_fm_write: cover property (@(posedge clk_sys) wr_fm && fm_ok);
  c_osc_loss: cover property (@(posedge clk_sys) $fell(osc_up) && r.clk_sel[RTC_CS_PT_SEL]);
  c_mod_tick: cover property (@(posedge clk_sys) modulation_tick);
endmodule // rtc_clock_select

`default_nettype wire

// *** src/rtc_pkg.sv ***
// Purpose: Shared constants and types for the timer clock-select and modulation control block
// Assumes: 8-bit registers on a 32-bit Avalon-MM slave, one word per register
// Notes: Register indices are word indices; byte address is four times the index
package rtc_pkg;
  // ==========================================================================
  // Register map
  localparam logic [3:0] RTC_IDX_CLK_SEL = 4'h9;
  localparam logic [3:0] RTC_IDX_FM = 4'ha;
  localparam logic [3:0] RTC_IDX_RATE = 4'hb;
  localparam logic [3:0] RTC_IDX_STATUS = 4'hc;
  localparam logic [3:0] RTC_IDX_CTRL = 4'hd;
  // ==========================================================================
  // Field positions
  localparam int RTC_CS_PSTOP_EN = 2;
  localparam int RTC_CS_PT_SEL = 1;
  localparam int RTC_CS_WD_LOW = 0;
  localparam int RTC_CS_WD_HIGH = 4;
  localparam int RTC_CS_PT_PSTOP_EN = 3;
  localparam int RTC_CS_PSTOP_SEL = 6;
  localparam int RTC_CS_LOOP_SEL = 7;
  localparam int RTC_CS_RSVD = 5;
  localparam int RTC_FM_HI = 5;
  localparam int RTC_FM_LO = 4;
  localparam int RTC_RATE_DEC = 7;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] RTC_CS_RESET = 8'h80;
  localparam logic [7:0] RTC_FM_RESET = 8'h00;
  localparam logic [7:0] RTC_RATE_RESET = 8'h00;
  localparam logic [7:0] RTC_FM_MASK = 8'h30;
  localparam logic [7:0] RTC_CS_W1_MASK = 8'h03;
  // Last modulation divider count; one period is 16 reference ticks
  localparam logic [3:0] RTC_FM_DIV_LAST = 4'hf;
  localparam int RTC_CNT_W = 21;
  localparam int RTC_DEC_W = 8;

  typedef struct packed {
    logic [7:0] clk_sel;
    logic [7:0] fm;
    logic [7:0] rate;
    logic [RTC_CNT_W-1:0] pre_cnt;
    logic [3:0] mod_cnt;
    logic [3:0] fm_div;
    logic fm_tick;
    logic pt_flag;
    logic wd_restart;
    logic pt_restart;
    logic lock_clr;
    logic osc_clr;
    logic rd_valid;
    logic [7:0] rd_data;
    logic [2:0] osc_sync;
    logic osc_up;
  } rtc_state_type;
endpackage

// *** verif/rtc_clock_select_tb_top.sv ***
// Purpose: Self-checking bench for the clock-select, modulation and periodic timer block
// Assumes: Avalon-MM slave with waitrequest; read data stands at the edge that sees waitrequest low
// Notes: Tick inputs run every cycle (RC) or every other cycle (osc, reference)
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
  $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end
module rtc_clock_select_tb_top;
  import rtc_pkg::*;
  logic clk_sys = 0, reset = 1, avs_read = 0, avs_write = 0, osc_up = 0, wprot = 0, stop = 0, half = 0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic avs_readdatavalid, avs_waitrequest, wdog_run, wdog_restart, pt_sel, pt_irq, mod_tick, lock_clr, osc_clr;
  logic [1:0] wdog_clk_source, modulation_amplitude;
  logic [7:0] rd;
  int n_mismatch = 0, n_tests = 0, n_wr = 0, n_irq = 0, n_lock = 0, n_osc = 0, g, k;
  // ==========================================================================
  // Clock, half-rate tick and pulse counters
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    half <= reset ? 1'b0 : ~half; // Osc and reference tick every other cycle
    n_wr <= n_wr + (wdog_restart === 1'b1);
    n_irq <= n_irq + (pt_irq === 1'b1);
    n_lock <= n_lock + (lock_clr === 1'b1);
    n_osc <= n_osc + (osc_clr === 1'b1);
  end
  rtc_clock_select DUT (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_readdatavalid(avs_readdatavalid), .avs_waitrequest(avs_waitrequest), .osc_up_status_pin(osc_up),
    .write_protect(wprot), .stop_mode(stop), .ref_tick(half), .pt_tick_rc(1'b1), .pt_tick_osc(half),
    .wdog_clk_source(wdog_clk_source), .wdog_run(wdog_run), .wdog_restart(wdog_restart),
    .periodic_timer_clk_select(pt_sel), .periodic_timer_irq(pt_irq), .modulation_amplitude(modulation_amplitude),
    .modulation_tick(mod_tick), .lock_clear(lock_clr), .osc_up_clear(osc_clr));
  // ==========================================================================
  // Verdict; reached from the main sequence and from an exhausted bus-cycle or gap wait
  task final_report();
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task timeout();
    n_mismatch++;
    $display("Error at %0t: wait ran out", $time);
    final_report();
  endtask
  // Bus cycles: request held until the edge that samples waitrequest low
  task wr(input logic [3:0] a, input logic [7:0] d);
    int i;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 50) timeout();
    avs_write <= 1'b0;
  endtask
  task rdreg(input logic [3:0] a);
    int i;
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 50) timeout();
    rd = avs_readdata[7:0];
    `CHK(avs_readdatavalid, 1'b1)
    avs_read <= 1'b0;
  endtask
  // Cycles between two pulses of the timer flag or the modulation tick
  task gap(input bit mod);
    int i, t0;
    t0 = -1;
    g = 0;
    for (i = 0; i < 9000 && g == 0; i++) begin
      @(negedge clk_sys);
      if ((mod ? mod_tick : pt_irq) === 1'b1) begin
        if (t0 < 0) t0 = i;
        else g = i - t0;
      end
    end
    if (g == 0) timeout();
  endtask
  // Write in mid-period, then time the first flag; without a restart it comes early
  task restart(input logic [3:0] a, input logic [7:0] d, input int p);
    int i;
    repeat (300) @(posedge clk_sys);
    wr(a, d);
    for (i = 0; i < 9000; i++) begin
      @(negedge clk_sys);
      if (pt_irq === 1'b1) break;
    end
    `CHK(i >= p - 4 && i <= p + 4, 1'b1)
  endtask
  task quiet();
    k = n_irq;
    repeat (2500) @(posedge clk_sys);
    `CHK(n_irq, k)
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    rdreg(RTC_IDX_CLK_SEL); `CHK(rd, RTC_CS_RESET)
    rdreg(RTC_IDX_FM); `CHK(rd, 8'h00)
    rdreg(RTC_IDX_RATE); `CHK(rd, 8'h00)
    rdreg(RTC_IDX_CTRL); `CHK(rd, 8'h00)
    wr(RTC_IDX_CLK_SEL, 8'h83); rdreg(RTC_IDX_CLK_SEL); `CHK(rd, 8'h80)
    `CHK(pt_sel, 1'b0)
    wr(RTC_IDX_FM, 8'hff); rdreg(RTC_IDX_FM); `CHK(rd, 8'h30)
    `CHK(n_lock, 1)
    `CHK(n_osc, 1)
    `CHK(modulation_amplitude, 2'b11)
    gap(1); `CHK(g, 32)
    for (k = 0; k < 3; k++) begin
      wr(RTC_IDX_FM, 8'(k << 4)); @(negedge clk_sys); `CHK(modulation_amplitude, 2'(k))
    end
    wprot <= 1'b1;
    wr(RTC_IDX_FM, 8'h10); rdreg(RTC_IDX_FM); `CHK(rd, 8'h20)
    `CHK(n_lock, 4)
    wprot <= 1'b0;
    wr(RTC_IDX_RATE, 8'h10); gap(0); `CHK(g, 1024)
    wr(RTC_IDX_RATE, 8'h21); gap(0); `CHK(g, 4096)
    wr(RTC_IDX_RATE, 8'h80); gap(0); `CHK(g, 1000)
    wr(RTC_IDX_RATE, 8'h10); restart(RTC_IDX_RATE, 8'h10, 1024);
    osc_up <= 1'b1;
    repeat (6) @(posedge clk_sys);
    wr(RTC_IDX_CLK_SEL, 8'h83); rdreg(RTC_IDX_CLK_SEL); `CHK(rd, 8'h83)
    `CHK(wdog_clk_source, 2'b01)
    gap(0); `CHK(g, 2048)
    restart(RTC_IDX_CLK_SEL, 8'h81, 1024);
    k = n_wr;
    wr(RTC_IDX_CLK_SEL, 8'h80); repeat (2) @(posedge clk_sys); `CHK(n_wr, k + 1)
    wr(RTC_IDX_CLK_SEL, 8'h91); repeat (2) @(posedge clk_sys); `CHK(wdog_clk_source, 2'b10)
    k = n_wr;
    wr(RTC_IDX_CLK_SEL, 8'h90); repeat (2) @(posedge clk_sys); `CHK(n_wr, k)
    `CHK(wdog_clk_source, 2'b10)
    stop <= 1'b1;
    @(negedge clk_sys); `CHK(wdog_run, 1'b0)
    wr(RTC_IDX_CLK_SEL, 8'hc5); @(negedge clk_sys); `CHK(wdog_run, 1'b1)
    quiet();
    wr(RTC_IDX_CLK_SEL, 8'hca); @(negedge clk_sys); `CHK(wdog_run, 1'b0)
    gap(0); `CHK(g, 2048)
    stop <= 1'b0;
    osc_up <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rdreg(RTC_IDX_CLK_SEL); `CHK(rd, 8'hc8)
    wr(RTC_IDX_RATE, 8'h00);
    quiet();
    final_report();
  end
endmodule // rtc_clock_select_tb_top
`default_nettype wire
